/* File: bench/sbc_ctrl.sv */
// Controller model that drives the command pins
`timescale 1ns/10ps
`default_nettype none
`include "sbc_defs.vh"
module sbc_ctrl (
  // Clock
  input  wire logic       sys_clk_i,
  // Command pins {cs_n, ras_n, cas_n, we_n}
  output var  logic       cke_o,
  output var  logic [3:0] cmd_o,
  output var  logic [1:0] bank_o,
  output var  logic       ap_o
);
  initial begin
    cke_o  = 1'b1;
    cmd_o  = `SBC_CMD_NOP;
    bank_o = 2'h0;
    ap_o   = 1'b0;
  end
  // Holds one command over exactly one edge, then NOP with address scrambled
  task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic a);
    @(posedge sys_clk_i);
    #1;
    cmd_o  = c;
    bank_o = b;
    ap_o   = a;
    @(posedge sys_clk_i);
    #1;
    cmd_o  = `SBC_CMD_NOP;
    bank_o = ~b;
    ap_o   = ~a;
  endtask
endmodule
`default_nettype wire

/* File: bench/sbc_top_assertions.sv */
// Assertions on the bank command tracker ports
`timescale 1ns/10ps
`default_nettype none
`include "sbc_defs.vh"
module sbc_chk #(
  parameter NB           = 4,
  parameter BURST_LENGTH = 8
) (
  // Clock, reset and command pins
  input wire logic            sys_clk_i,
  input wire logic            rst_i,
  input wire logic            cke_i,
  input wire logic            cs_n_i,
  input wire logic            ras_n_i,
  input wire logic            cas_n_i,
  input wire logic            we_n_i,
  input wire logic [1:0]      bank_i,
  input wire logic            ap_i,
  // Tracked state
  input wire logic [4*NB-1:0] bank_state_o,
  input wire logic [1:0]      dev_state_o,
  input wire logic [1:0]      last_read_bank_o,
  input wire logic            read_burst_o,
  input wire logic            illegal_o
);
  localparam int WGAP = 1 + BURST_LENGTH / 2 + `SBC_CYC(`SBC_WRITE_TO_READ_DELAY_NS);
  logic       cke_q;
  logic [1:0] nop_q;
  logic [3:0] wgap;
  logic [1:0] wbank;
  wire  [3:0] cmd   = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
  wire        ok    = cke_i & cke_q;
  wire        quiet = &nop_q;
  wire  [3:0] st    = bank_state_o[bank_i*4 +: 4];
  wire  [3:0] s0    = bank_state_o[3:0];
  // Edges since the last write with auto precharge
  always_ff @(posedge sys_clk_i) begin
    cke_q <= rst_i ? 1'b0 : cke_i;
    nop_q <= rst_i ? 2'h0 : {nop_q[0], cs_n_i | (cmd == `SBC_CMD_NOP)};
    if (rst_i) begin
      wgap <= 4'h0;
    end else if (ok && cmd == `SBC_CMD_WRITE && ap_i) begin
      wgap  <= 4'h1;
      wbank <= bank_i;
    end else if (wgap != 4'h0) begin
      wgap <= wgap + 4'h1;
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  a_rfr_enter: assert property (ok && cmd == `SBC_CMD_REFRESH && quiet && dev_state_o == 2'h0
    && bank_state_o == '0 && !read_burst_o |=> dev_state_o == 2'h1) else $error("no refresh");
  a_lmr_enter: assert property (ok && cmd == `SBC_CMD_LMR && quiet && dev_state_o == 2'h0
    && bank_state_o == '0 && !read_burst_o |=> dev_state_o == 2'h2) else $error("no mode set");
  a_preall_enter: assert property (ok && cmd == `SBC_CMD_PRE && ap_i && quiet
    && dev_state_o == 2'h0 |=> dev_state_o == 2'h3) else $error("no precharge all");
  a_rfr_refuse: assert property ($rose(dev_state_o == 2'h1) && ok
    && cmd == `SBC_CMD_ACTIVE |=> illegal_o) else $error("command in refresh taken");
  a_rfr_ends: assert property (dev_state_o == 2'h1 |-> ##[1:9] dev_state_o == 2'h0)
    else $error("refresh never ends");
  a_act_timing: assert property (s0 == 4'h1 && $past(s0) != 4'h1
    |=> s0 == 4'h1 ##1 s0 == 4'h2) else $error("activate time wrong");
  a_read_burst: assert property (ok && cmd == `SBC_CMD_READ && st == 4'h2 && quiet
    && dev_state_o == 2'h0 && wgap == 4'h0 && !read_burst_o
    |=> read_burst_o && last_read_bank_o == $past(bank_i)) else $error("read not tracked");
  a_bst_stop: assert property (ok && cmd == `SBC_CMD_BST && read_burst_o
    |-> ##[1:2] !read_burst_o) else $error("burst not stopped");
  a_wap_gap: assert property (ok && cmd == `SBC_CMD_READ && wgap != 4'h0 && wgap < WGAP
    && bank_i != wbank |=> illegal_o) else $error("early read taken");
  c_refresh: cover property (dev_state_o == 2'h1);
  c_illegal: cover property (illegal_o);
  c_wap: cover property (bank_state_o[7:4] == 4'h6);
endmodule
bind sbc_top sbc_chk #(.NB(NB), .BURST_LENGTH(BURST_LENGTH)) i_chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .cke_i(cke_i), .cs_n_i(cs_n_i),
  .ras_n_i(ras_n_i), .cas_n_i(cas_n_i), .we_n_i(we_n_i), .bank_i(bank_i), .ap_i(ap_i),
  .bank_state_o(bank_state_o), .dev_state_o(dev_state_o),
  .last_read_bank_o(last_read_bank_o), .read_burst_o(read_burst_o), .illegal_o(illegal_o));
`default_nettype wire

/* File: bench/tb_sbc_top.sv */
// Self-checking bench for the bank command tracker
`timescale 1ns/10ps
`default_nettype none
`include "sbc_defs.vh"
module tb_sbc_top;
  logic        sys_clk;
  logic        rst;
  logic        cke;
  logic [3:0]  cmd;
  logic [1:0]  bank;
  logic        ap;
  logic [15:0] bank_state;
  logic [1:0]  dev_state;
  logic [1:0]  last_read;
  logic        read_burst;
  logic        illegal;
  int          n_mismatch = 0;
  int          check_count = 0;
  sbc_top #(.BURST_LENGTH(8)) i_dut (
    .sys_clk_i(sys_clk), .rst_i(rst), .cke_i(cke), .cs_n_i(cmd[3]), .ras_n_i(cmd[2]),
    .cas_n_i(cmd[1]), .we_n_i(cmd[0]), .bank_i(bank), .ap_i(ap),
    .bank_state_o(bank_state), .dev_state_o(dev_state), .last_read_bank_o(last_read),
    .read_burst_o(read_burst), .illegal_o(illegal));
  sbc_ctrl i_ctl (.sys_clk_i(sys_clk), .cke_o(cke), .cmd_o(cmd), .bank_o(bank), .ap_o(ap));
  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic go(input logic [3:0] c, input logic [1:0] b, input logic a);
    i_ctl.issue(c, b, a);
  endtask
  function automatic logic [3:0] bs(input int b);
    return bank_state[b*4 +: 4];
  endfunction
  task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_activate;
    check("idle", {bank_state, dev_state, read_burst}, 16'h0000);
    go(`SBC_CMD_ACTIVE, 2'h0, 1'b0);
    tick(2);
    check("acting", bs(0), 4'h1);
    tick(2);
    check("active", bs(0), 4'h2);
    go(`SBC_CMD_ACTIVE, 2'h1, 1'b0);
    tick(4);
    check("other active", {bs(1), bs(0)}, 8'h22);
  endtask
  task automatic t_read_bst;
    go(`SBC_CMD_READ, 2'h0, 1'b0);
    go(`SBC_CMD_READ, 2'h1, 1'b0);
    go(`SBC_CMD_BST, 2'h0, 1'b0);
    tick(1);
    check("burst stop", read_burst, 1'b0);
    check("last read", last_read, 2'h1);
    tick(4);
    check("back active", bs(1), 4'h2);
  endtask
  task automatic t_write_in_read;
    go(`SBC_CMD_READ, 2'h0, 1'b0);
    go(`SBC_CMD_WRITE, 2'h1, 1'b0);
    check("write in read", illegal, 1'b1);
    tick(6);
    go(`SBC_CMD_WRITE, 2'h1, 1'b0);
    check("write later", illegal, 1'b0);
    tick(2);
    check("write state", bs(1), 4'h4);
    tick(10);
  endtask
  task automatic t_write_ap;
    go(`SBC_CMD_WRITE, 2'h1, 1'b1);
    go(`SBC_CMD_READ, 2'h0, 1'b0);
    check("write ap", bs(1), 4'h6);
    check("early read", illegal, 1'b1);
    tick(20);
    check("ap idle", bs(1), 4'h0);
    go(`SBC_CMD_ACTIVE, 2'h1, 1'b0);
    tick(4);
    go(`SBC_CMD_WRITE, 2'h1, 1'b1);
    go(`SBC_CMD_WRITE, 2'h0, 1'b0);
    check("early write", illegal, 1'b1);
    tick(2);
    go(`SBC_CMD_READ, 2'h0, 1'b0);
    check("read at gap", illegal, 1'b0);
    tick(20);
  endtask
  task automatic t_read_ap;
    go(`SBC_CMD_READ, 2'h0, 1'b1);
    tick(2);
    check("read ap", bs(0), 4'h5);
    tick(10);
    check("read ap idle", bs(0), 4'h0);
    go(`SBC_CMD_ACTIVE, 2'h0, 1'b0);
    tick(4);
  endtask
  task automatic t_busy;
    logic [3:0] c[3] = '{`SBC_CMD_PRE, `SBC_CMD_REFRESH, `SBC_CMD_LMR};
    logic [1:0] d[3] = '{2'h3, 2'h1, 2'h2};
    go(`SBC_CMD_REFRESH, 2'h0, 1'b0);
    check("refresh open", {dev_state, illegal}, 3'h1);
    for (int i = 0; i < 3; i++) begin
      go(c[i], 2'h0, i == 0);
      check("dev state", dev_state, d[i]);
      check("busy entry", illegal, 1'b0);
      if (i == 1) begin
        go(`SBC_CMD_ACTIVE, 2'h2, 1'b0);
        check("in refresh", illegal, 1'b1);
      end
      tick(12);
      check("all idle", {bank_state, dev_state}, 16'h0000);
    end
    go(4'hb, 2'h0, 1'b0);
    tick(2);
    check("deselect", bs(0), 4'h0);
  endtask
  initial begin
    rst = 1'b1;
    repeat (8) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    tick(1);
    t_activate();
    t_read_bst();
    t_write_in_read();
    t_write_ap();
    t_read_ap();
    t_busy();
    final_report();
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    n_mismatch++;
    final_report();
  end
endmodule
`default_nettype wire

/* File: hdl/sbc_bank.v */
// One bank's state machine with its timing counter
`timescale 1ns/10ps
`default_nettype none
`include "sbc_defs.vh"

module sbc_bank #(
  parameter CW = 8
) (
  // Clock and reset
  input  wire          sys_clk_i,
  input  wire          rst_i,
  // Command for this bank
  input  wire          act_i,
  input  wire          rd_i,
  input  wire          wr_i,
  input  wire          pre_i,
  input  wire          ap_i,
  input  wire          all_idle_i,
  // Timing and burst terminate from the top
  input  wire [CW-1:0] burst_cyc_i,
  input  wire [CW-1:0] trp_cyc_i,
  input  wire [CW-1:0] activate_to_column_delay_cyc_i,
  input  wire [CW-1:0] twr_cyc_i,
  input  wire          bst_i,
  // State
  output reg  [3:0]    state_o
);

  reg [CW-1:0] cnt;
  reg [3:0]    next_state;
  reg [CW-1:0] next_cnt;

  // ----------------------------------------------------------------
  // State update
  // ----------------------------------------------------------------
  always @* begin
    next_state = state_o;
    next_cnt   = (cnt != {CW{1'b0}}) ? cnt - 1'b1 : cnt;
    if (all_idle_i) begin
      next_state = `SBC_ST_IDLE;
      next_cnt   = {CW{1'b0}};
    end else begin
      case (state_o)
        `SBC_ST_IDLE: begin
          if (act_i) begin
            next_state = `SBC_ST_ACTING;
            next_cnt   = activate_to_column_delay_cyc_i;
          end
        end
        `SBC_ST_ACTING: begin
          if (cnt <= 1)
            next_state = `SBC_ST_ACTIVE;
        end
        `SBC_ST_ACTIVE, `SBC_ST_READ, `SBC_ST_WRITE, `SBC_ST_WREC: begin
          if (rd_i) begin
            next_state = ap_i ? `SBC_ST_READ_AP : `SBC_ST_READ;
            next_cnt   = burst_cyc_i;
          end else if (wr_i) begin
            next_state = ap_i ? `SBC_ST_WRITE_AP : `SBC_ST_WRITE;
            next_cnt   = burst_cyc_i + twr_cyc_i;
          end else if (pre_i) begin
            next_state = `SBC_ST_PRECHG;
            next_cnt   = trp_cyc_i;
          end else if (bst_i && state_o == `SBC_ST_READ) begin
            next_state = `SBC_ST_ACTIVE;
          end else if (state_o == `SBC_ST_READ && cnt <= 1) begin
            next_state = `SBC_ST_ACTIVE;
          end else if (state_o == `SBC_ST_WRITE && cnt <= 1) begin
            next_state = `SBC_ST_WREC;
            next_cnt   = twr_cyc_i;
          end else if (state_o == `SBC_ST_WREC && cnt <= 1) begin
            next_state = `SBC_ST_ACTIVE;
          end
        end
        `SBC_ST_READ_AP, `SBC_ST_WRITE_AP: begin
          // Access period, then internal precharge for row_precharge_time
          if (cnt <= 1) begin
            next_state = `SBC_ST_PRECHG;
            next_cnt   = trp_cyc_i;
          end
        end
        `SBC_ST_PRECHG: begin
          if (cnt <= 1)
            next_state = `SBC_ST_IDLE;
        end
        default: next_state = `SBC_ST_IDLE;
      endcase
    end
  end

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_o <= `SBC_ST_IDLE;
      cnt     <= {CW{1'b0}};
    end else begin
      state_o <= next_state;
      cnt     <= next_cnt;
    end
  end

endmodule
`default_nettype wire

/* File: hdl/sbc_defs.vh */
// Constants for the SDRAM bank command tracker
`ifndef SBC_DEFS_VH
`define SBC_DEFS_VH

// Command encodings {cs_n, ras_n, cas_n, we_n}
`define SBC_CMD_NOP      4'h7
`define SBC_CMD_ACTIVE   4'h3
`define SBC_CMD_READ     4'h5
`define SBC_CMD_WRITE    4'h4
`define SBC_CMD_PRE      4'h2
`define SBC_CMD_REFRESH  4'h1
`define SBC_CMD_LMR      4'h0
`define SBC_CMD_BST      4'h6

// Bank states
`define SBC_ST_IDLE      4'h0
`define SBC_ST_ACTING    4'h1
`define SBC_ST_ACTIVE    4'h2
`define SBC_ST_READ      4'h3
`define SBC_ST_WRITE     4'h4
`define SBC_ST_READ_AP   4'h5
`define SBC_ST_WRITE_AP  4'h6
`define SBC_ST_PRECHG    4'h7
`define SBC_ST_WREC      4'h8

// Device-wide states
`define SBC_DEV_NORMAL   2'h0
`define SBC_DEV_REFRESH  2'h1
`define SBC_DEV_MODESET  2'h2
`define SBC_DEV_PREALL   2'h3

// Timing figures in ns, and the clock period in ns
`define SBC_CLK_NS       10
`define SBC_TRP_NS       15
`define SBC_REFRESH_CYCLE_TIME_NS      72
`define SBC_MODE_SET_TIME_NS      10
`define SBC_ACTIVATE_TO_COLUMN_DELAY_NS      15
`define SBC_TWR_NS       15
`define SBC_WRITE_TO_READ_DELAY_NS      10

// Least times round up to whole cycles
`define SBC_CYC(ns) (((ns) + `SBC_CLK_NS - 1) / `SBC_CLK_NS)

// Field position of the address bus and default burst length
`define SBC_AP_BIT       10
`define SBC_BL_DEFAULT   8

`endif

/* File: hdl/sbc_top.v */
// Four-bank SDRAM command decoder and bank state tracker
// Notes on behaviour
// - Read with auto precharge, idle after precharge
// - Write with auto precharge, idle after precharge
// - Burst terminate stops latest read burst
// - Command decode from four strobe pins
// - Other bank accepts its own legal commands
// - Idle first bank never blocks others
// - Idle and row-active state definitions
// - Burst state until finished or terminated
// - Concurrent auto precharge allows other banks
// - Read auto precharge starts at earliest precharge
// - Write auto precharge after write recovery
// - Access period then row precharge period
// - Precharging state lasts row precharge time
// - Activating state lasts activate delay
`timescale 1ns/10ps
`default_nettype none
`include "sbc_defs.vh"

module sbc_top #(
  parameter NB = 4,
  parameter CW = 8,
  parameter BURST_LENGTH = `SBC_BL_DEFAULT
) (
  // Clock and reset
  input  wire            sys_clk_i,
  input  wire            rst_i,
  // Command pins, active high cke_i and active low strobes
  input  wire            cke_i,
  input  wire            cs_n_i,
  input  wire            ras_n_i,
  input  wire            cas_n_i,
  input  wire            we_n_i,
  input  wire [1:0]      bank_i,
  input  wire            ap_i,
  // Tracked state
  output reg  [4*NB-1:0] bank_state_o,
  output reg  [1:0]      dev_state_o,
  output reg  [1:0]      last_read_bank_o,
  output reg             read_burst_o,
  output reg             illegal_o
);

  localparam [CW-1:0] ROW_PRECHARGE_TIME  = `SBC_CYC(`SBC_TRP_NS);
  localparam [CW-1:0] REFRESH_CYCLE_TIME = `SBC_CYC(`SBC_REFRESH_CYCLE_TIME_NS);
  localparam [CW-1:0] MODE_SET_TIME = `SBC_CYC(`SBC_MODE_SET_TIME_NS);
  localparam [CW-1:0] ACTIVATE_TO_COLUMN_DELAY = `SBC_CYC(`SBC_ACTIVATE_TO_COLUMN_DELAY_NS);
  localparam [CW-1:0] WRITE_RECOVERY_TIME  = `SBC_CYC(`SBC_TWR_NS);
  localparam [CW-1:0] WRITE_TO_READ_DELAY = `SBC_CYC(`SBC_WRITE_TO_READ_DELAY_NS);
  localparam [CW-1:0] HALF = BURST_LENGTH / 2;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  reg        cke_prev;
  wire       valid   = cke_prev & cke_i;
  wire [3:0] cmd     = cs_n_i ? `SBC_CMD_NOP
                              : {1'b0, ras_n_i, cas_n_i, we_n_i};
  wire       is_act  = valid & (cmd == `SBC_CMD_ACTIVE);
  wire       is_rd   = valid & (cmd == `SBC_CMD_READ);
  wire       is_wr   = valid & (cmd == `SBC_CMD_WRITE);
  wire       is_pre  = valid & (cmd == `SBC_CMD_PRE);
  wire       is_ref  = valid & (cmd == `SBC_CMD_REFRESH);
  wire       is_lmr  = valid & (cmd == `SBC_CMD_LMR);
  wire       is_bst  = valid & (cmd == `SBC_CMD_BST);
  wire       is_nop  = (cmd == `SBC_CMD_NOP);
  wire       pre_all = is_pre & ap_i;

  wire [4*NB-1:0] st;
  reg  [CW-1:0]   dev_cnt;
  reg  [CW-1:0]   rd_cnt;
  reg  [CW-1:0]   wap_cnt;
  reg  [1:0]      wap_bank;
  reg             busy_dev;
  wire            all_idle;

  function is_idle;
    input [3:0] s;
    begin
      is_idle = (s == `SBC_ST_IDLE);
    end
  endfunction

  function can_col;
    input [3:0] s;
    begin
      can_col = (s == `SBC_ST_ACTIVE) | (s == `SBC_ST_READ) |
                (s == `SBC_ST_WRITE) | (s == `SBC_ST_WREC);
    end
  endfunction

  // ----------------------------------------------------------------
  // Banks
  // ----------------------------------------------------------------
  wire [NB-1:0] idle_v;
  wire [NB-1:0] pre_ok_v;
  genvar g;
  generate
    for (g = 0; g < NB; g = g + 1) begin : gb
      wire sel = (bank_i == g);
      // Each bank reacts to its own command or to a precharge all, so others proceed freely
      sbc_bank #(.CW(CW)) u_bank (
        .sys_clk_i   (sys_clk_i),
        .rst_i       (rst_i),
        .act_i       (is_act & sel & ~busy_dev),
        .rd_i        (is_rd & sel & ~busy_dev),
        .wr_i        (is_wr & sel & ~busy_dev),
        .pre_i       (is_pre & (sel | ap_i) & ~busy_dev),
        .ap_i        (ap_i),
        .all_idle_i  (1'b0),
        .burst_cyc_i (HALF),
        .trp_cyc_i   (ROW_PRECHARGE_TIME),
        .activate_to_column_delay_cyc_i  (ACTIVATE_TO_COLUMN_DELAY),
        .twr_cyc_i   (WRITE_RECOVERY_TIME),
        .bst_i       (is_bst & (last_read_bank_o == g) & read_burst_o),
        .state_o     (st[4*g+3:4*g])
      );
      assign idle_v[g]   = is_idle(st[4*g+3:4*g]);
      assign pre_ok_v[g] = idle_v[g] | can_col(st[4*g+3:4*g]) |
                           (st[4*g+3:4*g] == `SBC_ST_PRECHG);
    end
  endgenerate

  assign all_idle = &idle_v;
  wire [3:0] sel_st = st[4*bank_i+:4];

  // ----------------------------------------------------------------
  // Legality check of the incoming command
  // ----------------------------------------------------------------
  reg bad;
  always @* begin
    bad = 1'b0;
    if (busy_dev)
      bad = valid & ~is_nop;
    else if (is_ref | is_lmr)
      bad = ~all_idle | read_burst_o;
    else if (is_act)
      bad = ~is_idle(sel_st);
    else if (is_rd)
      bad = ~can_col(sel_st) |
            ((wap_cnt != {CW{1'b0}}) & (wap_bank != bank_i));
    else if (is_wr)
      bad = ~can_col(sel_st) | (read_burst_o & (rd_cnt > 1)) |
            ((wap_cnt > 1 + WRITE_TO_READ_DELAY) & (wap_bank != bank_i));
    else if (pre_all)
      bad = ~&pre_ok_v;
    else if (is_pre)
      bad = ~pre_ok_v[bank_i];
    else if (is_bst)
      bad = ~read_burst_o;
    else if (valid)
      bad = ~is_nop;
  end

  // ----------------------------------------------------------------
  // Device-wide state, latest read and write-AP spacing
  // ----------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      cke_prev         <= 1'b0;
      dev_state_o      <= `SBC_DEV_NORMAL;
      dev_cnt          <= {CW{1'b0}};
      busy_dev         <= 1'b0;
      rd_cnt           <= {CW{1'b0}};
      read_burst_o     <= 1'b0;
      last_read_bank_o <= 2'h0;
      wap_cnt          <= {CW{1'b0}};
      wap_bank         <= 2'h0;
      bank_state_o     <= {4*NB{1'b0}};
      illegal_o        <= 1'b0;
    end else begin
      cke_prev     <= cke_i;
      bank_state_o <= st;
      illegal_o    <= bad;
      if (busy_dev) begin
        if (dev_cnt <= 1) begin
          busy_dev    <= 1'b0;
          dev_state_o <= `SBC_DEV_NORMAL;
        end
        dev_cnt <= dev_cnt - 1'b1;
      end else if (is_ref & ~bad) begin
        busy_dev    <= 1'b1;
        dev_state_o <= `SBC_DEV_REFRESH;
        dev_cnt     <= REFRESH_CYCLE_TIME;
      end else if (is_lmr & ~bad) begin
        busy_dev    <= 1'b1;
        dev_state_o <= `SBC_DEV_MODESET;
        dev_cnt     <= MODE_SET_TIME;
      end else if (pre_all & ~bad) begin
        busy_dev    <= 1'b1;
        dev_state_o <= `SBC_DEV_PREALL;
        dev_cnt     <= ROW_PRECHARGE_TIME;
      end
      // Latest read burst tracking
      if (is_rd & ~busy_dev) begin
        read_burst_o     <= 1'b1;
        last_read_bank_o <= bank_i;
        rd_cnt           <= HALF;
      end else if (is_bst | (is_wr & ~busy_dev) | (rd_cnt <= 1)) begin
        read_burst_o <= 1'b0;
        rd_cnt       <= {CW{1'b0}};
      end else begin
        rd_cnt <= rd_cnt - 1'b1;
      end
      // Other-bank spacing after a write with auto precharge
      if (is_wr & ap_i & ~busy_dev) begin
        // Counter reads zero on the edge the spacing is first met
        wap_cnt  <= HALF + WRITE_TO_READ_DELAY;
        wap_bank <= bank_i;
      end else if (wap_cnt != {CW{1'b0}}) begin
        wap_cnt <= wap_cnt - 1'b1;
      end
    end
  end

endmodule
`default_nettype wire
